// ==== rtl/timer_counter_pkg.sv ====
// constants and types shared by the timer-counter block
package timer_counter_pkg;

  // apb register byte offsets
  localparam logic [7:0] COUNT_OFFSET  = 8'h00;
  localparam logic [7:0] CTRL_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] BUFFER_OFFSET = 8'h0C;

  // ctrl register fields
  localparam int CMD_LSB  = 0;
  localparam int CMD_W    = 4;
  localparam int MODE_LSB = 0;

  // status register fields
  localparam int ST_IRQ_FLAG  = 0;
  localparam int ST_IRQ_EN    = 1;
  localparam int ST_TOGGLE_EN = 2;
  localparam int ST_Q         = 3;
  localparam int ST_FLAG_ONE  = 4;
  localparam int ST_FLAG_TWO  = 5;
  localparam int ST_PRESC_LSB = 8;

  // command codes written to ctrl
  localparam logic [3:0] CMD_NONE        = 4'h0;
  localparam logic [3:0] CMD_STOP        = 4'h1;
  localparam logic [3:0] CMD_DECREMENT   = 4'h2;
  localparam logic [3:0] CMD_EVENT_ONE   = 4'h3;
  localparam logic [3:0] CMD_EVENT_TWO   = 4'h4;
  localparam logic [3:0] CMD_TIMER       = 4'h5;
  localparam logic [3:0] CMD_PULSE_ONE   = 4'h6;
  localparam logic [3:0] CMD_PULSE_TWO   = 4'h7;
  localparam logic [3:0] CMD_TOGGLE_ON   = 4'h8;
  localparam logic [3:0] CMD_TOGGLE_OFF  = 4'h9;
  localparam logic [3:0] CMD_IRQ_EN_SET  = 4'hA;
  localparam logic [3:0] CMD_IRQ_EN_CLR  = 4'hB;

  // timing and reset values
  localparam int         PRESC_DIV      = 32;
  localparam int         COUNT_W        = 8;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] COUNT_WRAP_AT  = 8'h01;
  localparam logic       IRQ_EN_RESET   = 1'b1;

  // counting modes
  typedef enum logic [2:0] {
    MODE_STOPPED,
    MODE_EVENT_ONE,
    MODE_EVENT_TWO,
    MODE_TIMER,
    MODE_PULSE_ONE,
    MODE_PULSE_TWO
  } mode_t;

endpackage : timer_counter_pkg

// ==== rtl/cpu_timer_counter.sv ====
// presettable down-counter with prescaler, modes and apb registers
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps

// Summary of operation
// - 8-bit down-counter, selectable count sources
// - at 01 next count reloads, sets irq
// - preset zero gives 256 counts per period
// - load sets counter and buffer, clears irq unless a wrap hits in the same cycle
// - reading counter changes nothing
// - event modes count falling flag edges
// - timer counts prescaler out, rising pulse
// - prescaler held reset unless timer running
// - pulse modes count pulses while flag low
// - flag release stops, clears mode, sets irq
// - pulse-mode wrap sets irq, keeps counting
// - flags still visible for branch testing
// - stop clears mode, keeps count value
// - decrement command counts one in software
// - toggle enabled: q flips on wrap
// - cpu reset sets prescaler to top, clears irq; sets enable
// - no event counting during pause
// - timing pulse once per machine cycle
module cpu_timer_counter
  import timer_counter_pkg::*;
#(
  parameter int CNT_W = timer_counter_pkg::COUNT_W,
  parameter int DIV   = timer_counter_pkg::PRESC_DIV
) (
  // clock, reset, clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // processor reset mode, synchronous, active high
  input  wire logic        cpu_reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // count inputs, flags are active low pins
  input  wire logic        flag_input_one_n,
  input  wire logic        flag_input_two_n,
  input  wire logic        cycle_timing_pulse,
  // outputs
  output logic             counter_irq,
  output logic             q_out,
  output logic             flag_test_one,
  output logic             flag_test_two
);
  import timer_counter_pkg::*;

  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0]    PRESC_TOP = PW'(DIV - 1);
  localparam logic [CNT_W-1:0] WRAP_AT   = CNT_W'(COUNT_WRAP_AT);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] preset;
    mode_t            mode;
    logic [PW-1:0]    presc;
    logic             irq_flag;
    logic             irq_en;
    logic             toggle_en;
    logic             q;
    logic             f1_prev;
    logic             f2_prev;
    logic             tpa_prev;
    logic             f1_q;
    logic             f2_q;
    logic [31:0]      rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  // word-aligned map of four registers; anything else errors
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = addr_is(a, COUNT_OFFSET) ||
                addr_is(a, CTRL_OFFSET) ||
                addr_is(a, STATUS_OFFSET) ||
                addr_is(a, BUFFER_OFFSET);
  endfunction : is_mapped

  // pin edges against the sample of the last enabled clock
  function automatic logic fell_edge(input logic now_v,
                                     input logic prev_v);
    fell_edge = !now_v && prev_v;
  endfunction : fell_edge

  function automatic logic rose_edge(input logic now_v,
                                     input logic prev_v);
    rose_edge = now_v && !prev_v;
  endfunction : rose_edge

  // the step from 01 that reloads the preset
  function automatic logic wrap_hit(input logic             t,
                                    input logic [CNT_W-1:0] c);
    wrap_hit = t && (c == WRAP_AT);
  endfunction : wrap_hit

  // prescaler runs top down to zero; held at top outside timer
  function automatic logic [PW-1:0] presc_next(input mode_t         m,
                                               input logic          up,
                                               input logic [PW-1:0] p);
    presc_next = p;
    if (m != MODE_TIMER) begin
      presc_next = PRESC_TOP;
    end else if (up) begin
      if (p == '0) begin
        presc_next = PRESC_TOP;
      end else begin
        presc_next = p - 1'b1;
      end
    end
  endfunction : presc_next

  // selected count source, one request per enabled clock
  function automatic logic src_tick(input mode_t m,
                                    input logic  ev_one,
                                    input logic  ev_two,
                                    input logic  pre_out,
                                    input logic  tpa_up,
                                    input logic  one_n,
                                    input logic  two_n);
    src_tick = 1'b0;
    case (m)
      MODE_EVENT_ONE: begin
        src_tick = ev_one;
      end
      MODE_EVENT_TWO: begin
        src_tick = ev_two;
      end
      MODE_TIMER: begin
        src_tick = pre_out;
      end
      MODE_PULSE_ONE: begin
        src_tick = tpa_up && !one_n;
      end
      MODE_PULSE_TWO: begin
        src_tick = tpa_up && !two_n;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase
  endfunction : src_tick

  // mode commands; anything else keeps the current mode
  function automatic mode_t next_mode(input logic [3:0] c,
                                      input mode_t      m);
    next_mode = m;
    case (c)
      CMD_STOP: begin
        next_mode = MODE_STOPPED;
      end
      CMD_EVENT_ONE: begin
        next_mode = MODE_EVENT_ONE;
      end
      CMD_EVENT_TWO: begin
        next_mode = MODE_EVENT_TWO;
      end
      CMD_TIMER: begin
        next_mode = MODE_TIMER;
      end
      CMD_PULSE_ONE: begin
        next_mode = MODE_PULSE_ONE;
      end
      CMD_PULSE_TWO: begin
        next_mode = MODE_PULSE_TWO;
      end
      default: begin
        next_mode = m;
      end
    endcase
  endfunction : next_mode

  // read word built from a copy; no state is touched
  function automatic logic [31:0] read_word(input state_t     s,
                                            input logic [7:0] a);
    read_word = '0;
    if (addr_is(a, COUNT_OFFSET)) begin
      read_word[CNT_W-1:0] = s.count;
    end else if (addr_is(a, BUFFER_OFFSET)) begin
      read_word[CNT_W-1:0] = s.preset;
    end else if (addr_is(a, CTRL_OFFSET)) begin
      read_word[MODE_LSB +: 3] = s.mode;
    end else if (addr_is(a, STATUS_OFFSET)) begin
      read_word[ST_IRQ_FLAG]        = s.irq_flag;
      read_word[ST_IRQ_EN]          = s.irq_en;
      read_word[ST_TOGGLE_EN]       = s.toggle_en;
      read_word[ST_Q]               = s.q;
      read_word[ST_FLAG_ONE]        = s.f1_q;
      read_word[ST_FLAG_TWO]        = s.f2_q;
      read_word[ST_PRESC_LSB +: PW] = s.presc;
    end
  endfunction : read_word

  logic       setup;
  logic       wr;
  logic       mapped;
  logic [3:0] cmd;
  logic       tpa_rise;
  logic       f1_fall;
  logic       f2_fall;
  logic       f1_rise;
  logic       f2_rise;
  logic       tick;
  logic       presc_out;

  assign setup  = psel && !penable;
  assign wr     = ce && psel && penable && pwrite;
  assign mapped = is_mapped(paddr);
  assign cmd    = (wr && addr_is(paddr, CTRL_OFFSET)) ?
                  pwdata[CMD_LSB +: CMD_W] : CMD_NONE;

  // edges taken against the previous sample of each pin
  assign tpa_rise = rose_edge(cycle_timing_pulse, s_q.tpa_prev);
  assign f1_fall  = fell_edge(flag_input_one_n, s_q.f1_prev);
  assign f2_fall  = fell_edge(flag_input_two_n, s_q.f2_prev);
  assign f1_rise  = rose_edge(flag_input_one_n, s_q.f1_prev);
  assign f2_rise  = rose_edge(flag_input_two_n, s_q.f2_prev);

  assign presc_out = tpa_rise && (s_q.presc == '0);

  // count source select
  always_comb begin
    tick = src_tick(s_q.mode, f1_fall, f2_fall, presc_out, tpa_rise,
                    flag_input_one_n, flag_input_two_n);
    if (cmd == CMD_DECREMENT) begin
      tick = 1'b1;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.f1_prev  = flag_input_one_n;
    s_d.f2_prev  = flag_input_two_n;
    s_d.tpa_prev = cycle_timing_pulse;
    s_d.f1_q     = !flag_input_one_n;
    s_d.f2_q     = !flag_input_two_n;

    // prescaler
    s_d.presc = presc_next(s_q.mode, tpa_rise, s_q.presc);

    // counter; zero decrements to all ones, giving 256 counts
    if (wrap_hit(tick, s_q.count)) begin
      s_d.count    = s_q.preset;
      s_d.irq_flag = 1'b1;
      if (s_q.toggle_en) begin
        s_d.q = !s_q.q;
      end
    end else if (tick) begin
      s_d.count = s_q.count - 1'b1;
    end

    // pulse end: stop and latch request
    if ((s_q.mode == MODE_PULSE_ONE && f1_rise) ||
        (s_q.mode == MODE_PULSE_TWO && f2_rise)) begin
      s_d.mode     = MODE_STOPPED;
      s_d.irq_flag = 1'b1;
    end

    // commands; a new mode replaces the old one
    s_d.mode = next_mode(cmd, s_d.mode);
    case (cmd)
      CMD_TOGGLE_ON: begin
        s_d.toggle_en = 1'b1;
      end
      CMD_TOGGLE_OFF: begin
        s_d.toggle_en = 1'b0;
      end
      CMD_IRQ_EN_SET: begin
        s_d.irq_en = 1'b1;
      end
      CMD_IRQ_EN_CLR: begin
        s_d.irq_en = 1'b0;
      end
      default: begin
        s_d.irq_en = s_d.irq_en;
      end
    endcase
    if (cmd == CMD_STOP) begin
      s_d.presc = PRESC_TOP;
    end

    // load: a wrap in the same cycle still leaves the flag set
    if (wr && addr_is(paddr, COUNT_OFFSET)) begin
      s_d.count    = pwdata[CNT_W-1:0];
      s_d.preset   = pwdata[CNT_W-1:0];
      s_d.irq_flag = wrap_hit(tick, s_q.count);
    end

    // processor reset keeps count, preset and mode
    if (cpu_reset) begin
      s_d.presc    = PRESC_TOP;
      s_d.irq_flag = 1'b0;
      s_d.irq_en   = IRQ_EN_RESET;
      s_d.q        = 1'b0;
    end

    // read data captured in setup; reads touch no state
    if (setup && !pwrite) begin
      s_d.rdata = read_word(s_q, paddr);
    end
  end

  // count and preset have no documented reset; power-on gives zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.count     <= CNT_W'(COUNT_RESET);
      s_q.preset    <= CNT_W'(COUNT_RESET);
      s_q.mode      <= MODE_STOPPED;
      s_q.presc     <= PRESC_TOP;
      s_q.irq_en    <= IRQ_EN_RESET;
      s_q.f1_prev   <= 1'b1;
      s_q.f2_prev   <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // apb answers in the access cycle while ce is high
  assign pready        = ce;
  assign pslverr       = psel && penable && !mapped;
  assign prdata        = s_q.rdata;
  assign counter_irq   = s_q.irq_flag && s_q.irq_en;
  assign q_out         = s_q.q;
  assign flag_test_one = s_q.f1_q;
  assign flag_test_two = s_q.f2_q;

endmodule : cpu_timer_counter

// ==== tb/tpa_gen.sv ====
// timing pulse source, one pulse per machine cycle
`timescale 1ns/100ps
module tpa_gen #(parameter int P = 8) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pulse out
  output logic      cycle_timing_pulse
);
  int n;
  // no pulse while reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n <= 0;
      cycle_timing_pulse <= 1'b0;
    end else begin
      n <= (n == P - 1) ? 0 : n + 1;
      cycle_timing_pulse <= (n == 0);
    end
  end
endmodule : tpa_gen

// ==== tb/cpu_timer_counter_chk.sv ====
// port assertions for the timer-counter block
`timescale 1ns/100ps
module cpu_timer_counter_chk
  import timer_counter_pkg::*;
(
  // clock, reset, control
  input wire logic        pclk, presetn, ce, cpu_reset,
  // apb
  input wire logic        psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // pins
  input wire logic        flag_input_one_n, flag_input_two_n,
  input wire logic        cycle_timing_pulse, counter_irq, q_out,
  input wire logic        flag_test_one, flag_test_two
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, bad, wr;
  assign acc = psel && penable && ce;
  assign bad = paddr > 8'h0C || paddr[1:0] != 2'b00;
  assign wr  = acc && pwrite && !bad;
  a_err_decode: assert property (acc |-> pslverr == bad)
    else $error("error response mismatch");
  a_rd_zero: assert property (acc && bad && !pwrite |-> prdata == 0)
    else $error("unmapped read not zero");
  a_flag_one: assert property (
    ce |=> flag_test_one == !$past(flag_input_one_n)
  ) else $error("flag one view wrong");
  a_flag_two: assert property (
    ce |=> flag_test_two == !$past(flag_input_two_n)
  ) else $error("flag two view wrong");
  // enable clear through ctrl may also drop the output
  a_irq_hold: assert property (
    $fell(counter_irq) |-> $past(cpu_reset) || $past(cpu_reset, 2) ||
      $past(wr && paddr <= CTRL_OFFSET)
  ) else $error("irq dropped without cause");
  a_irq_load: assert property (
    wr && paddr == COUNT_OFFSET |=> !counter_irq
  ) else $error("load kept irq");
  a_irq_cpu_rst: assert property (
    cpu_reset && ce |-> ##[1:2] !counter_irq
  ) else $error("cpu reset kept irq");
  a_q_cpu_rst: assert property (
    cpu_reset && ce |-> ##[1:2] !q_out
  ) else $error("cpu reset kept q");
  c_irq: cover property ($rose(counter_irq));
  c_q: cover property ($changed(q_out));
  c_err: cover property (acc && pslverr);
endmodule : cpu_timer_counter_chk

// ==== tb/cpu_timer_counter_tb.sv ====
// self-checking bench for the timer-counter block
`timescale 1ns/100ps
module cpu_timer_counter_tb;
  import timer_counter_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, cpu_reset = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic flag_input_one_n = 1, flag_input_two_n = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, counter_irq, q_out, flag_test_one;
  logic flag_test_two, cycle_timing_pulse;
  logic irq = 0, en = 1, tog = 0, q = 0;
  logic [31:0] seed = 32'd10173;
  int n_fail = 0, check_count = 0, cnt = 0, pre = 0, v;
  cpu_timer_counter DUT (.*);
  tpa_gen #(.P(8)) u_tpa (.pclk(pclk), .presetn(presetn),
    .cycle_timing_pulse(cycle_timing_pulse));
  initial forever #4 pclk = ~pclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] st();
    return {19'h0, 5'h1F, 4'h0, q, tog, en, irq};
  endfunction : st
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic cmd(input logic [3:0] c);
    apb(1, CTRL_OFFSET, int'(c));
  endtask : cmd
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(r, e);
  endtask : rd
  task automatic tick();
    if (cnt == 1) begin
      cnt = pre;
      irq = 1;
      q ^= tog;
    end else cnt = (cnt == 0) ? 255 : cnt - 1;
  endtask : tick
  task automatic ld(input int x);
    cmd(CMD_STOP);
    apb(1, COUNT_OFFSET, x);
    cnt = x;
    pre = x;
    irq = 0;
  endtask : ld
  task automatic edges(input int k, input logic two);
    repeat (k) begin
      if (two) flag_input_two_n <= 0;
      else flag_input_one_n <= 0;
      repeat (3) @(posedge pclk);
      flag_input_one_n <= 1;
      flag_input_two_n <= 1;
      repeat (3) @(posedge pclk);
    end
  endtask : edges
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // whole run is a few thousand cycles
  initial begin
    #80000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(COUNT_OFFSET, 0);
    rd(STATUS_OFFSET, st());
    apb(1, STATUS_OFFSET, -1);
    rd(STATUS_OFFSET, st());
    rd(8'h10, 0);
    $display("reset test done");
    v = 2 + int'(xs() % 16);
    ld(v);
    cmd(CMD_TOGGLE_ON);
    tog = 1;
    repeat (v) begin
      cmd(CMD_DECREMENT);
      tick();
    end
    rd(COUNT_OFFSET, cnt);
    rd(COUNT_OFFSET, cnt);
    rd(STATUS_OFFSET, st());
    chk(q_out, q);
    rd(BUFFER_OFFSET, pre);
    $display("decrement test done");
    ld(0);
    rd(STATUS_OFFSET, st());
    cmd(CMD_EVENT_ONE);
    edges(256, 0);
    repeat (256) tick();
    rd(COUNT_OFFSET, cnt);
    rd(STATUS_OFFSET, st());
    cmd(CMD_EVENT_TWO);
    edges(3, 0);
    edges(3, 1);
    repeat (3) tick();
    rd(COUNT_OFFSET, cnt);
    rd(CTRL_OFFSET, 2);
    ce <= 0;
    edges(2, 1);
    ce <= 1;
    rd(COUNT_OFFSET, cnt);
    $display("event test done");
    ld(2);
    @(posedge cycle_timing_pulse);
    cmd(CMD_TIMER);
    repeat (64) @(posedge cycle_timing_pulse);
    repeat (2) tick();
    cmd(CMD_STOP);
    rd(STATUS_OFFSET, st());
    repeat (16) @(posedge cycle_timing_pulse);
    rd(COUNT_OFFSET, cnt);
    $display("timer test done");
    for (int i = 0; i < 2; i++) begin
      ld(i ? 3 : 10);
      if (i) flag_input_two_n <= 0;
      else flag_input_one_n <= 0;
      @(posedge cycle_timing_pulse);
      cmd(i ? CMD_PULSE_TWO : CMD_PULSE_ONE);
      repeat (5) @(posedge cycle_timing_pulse);
      repeat (3) @(posedge pclk);
      flag_input_one_n <= 1;
      flag_input_two_n <= 1;
      repeat (5) tick();
      irq = 1;
      repeat (2) @(posedge cycle_timing_pulse);
      rd(CTRL_OFFSET, 0);
      rd(COUNT_OFFSET, cnt);
      rd(STATUS_OFFSET, st());
    end
    $display("pulse test done");
    cmd(CMD_NONE);
    cmd(CMD_TOGGLE_OFF);
    cmd(CMD_IRQ_EN_CLR);
    tog = 0;
    en = 0;
    rd(STATUS_OFFSET, st());
    chk(counter_irq, 0);
    cmd(CMD_IRQ_EN_SET);
    en = 1;
    rd(STATUS_OFFSET, st());
    chk(counter_irq, 1);
    cpu_reset <= 1;
    @(posedge pclk);
    cpu_reset <= 0;
    irq = 0;
    q = 0;
    repeat (2) @(posedge pclk);
    rd(COUNT_OFFSET, cnt);
    rd(STATUS_OFFSET, st());
    $display("cpu reset test done");
    end_sim();
  end
endmodule : cpu_timer_counter_tb
bind cpu_timer_counter cpu_timer_counter_chk u_chk (.*);
